// ===== shared/ccer_pkg.sv
// constants and carrier types for counter channel event reporting
// assumes a 32-bit classic wishbone register bus, word-aligned registers
package ccer_pkg;

   localparam int CCER_NCHAN = 4;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL      = 8'h00;
   localparam logic [7:0] IDX_EVT_EN    = 8'h01;
   localparam logic [7:0] IDX_ACK       = 8'h02;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'h03;
   localparam logic [7:0] IDX_IRQ_CLR   = 8'h04;
   localparam logic [7:0] IDX_IRQ_EN    = 8'h05;
   localparam logic [7:0] IDX_PROC_SRC  = 8'h06;
   localparam logic [7:0] IDX_HISTORY   = 8'h07;
   localparam logic [7:0] IDX_PCAUSE_A  = 8'h08;
   localparam logic [7:0] IDX_PCAUSE_B  = 8'h09;
   localparam logic [7:0] IDX_PCAUSE_C  = 8'h0a;
   localparam logic [7:0] IDX_PCAUSE_D  = 8'h0b;
   localparam logic [7:0] IDX_DIAG_SRC  = 8'h16;
   localparam logic [7:0] IDX_DCAUSE_A  = 8'h18;
   localparam logic [7:0] IDX_DCAUSE_B  = 8'h1b;

   // control register fields
   localparam int CTRL_SEL_LSB     = 0;   // 2 bits interrupt selection
   localparam int CTRL_MODE_LSB    = 2;   // 2 bits per channel
   localparam int CTRL_PHND_BIT    = 10;  // process handler installed
   localparam int CTRL_DHND_BIT    = 11;  // diagnostic handler installed
   localparam int CTRL_W           = 12;
   localparam int EVT_EN_PER_CH    = 5;
   localparam int EVT_EN_W         = 20;

   // ack register bits
   localparam int ACK_PROC_BIT     = 0;
   localparam int ACK_DIAG_BIT     = 1;
   localparam int ACK_HALT_BIT     = 2;

   // interrupt status bits
   localparam int ST_PROC_BIT      = 0;
   localparam int ST_DIN_BIT       = 1;
   localparam int ST_DOUT_BIT      = 2;
   localparam int ST_LOST_BIT      = 3;
   localparam int ST_HALT_BIT      = 4;
   localparam int ST_W             = 5;

   // diagnostic byte field positions
   localparam int DA_FAULTY_BIT    = 0;
   localparam int DA_CFG_BIT       = 7;
   localparam int DB_LOST_BIT      = 6;

   // cause nibble positions inside a channel
   localparam int NB_GOPEN         = 0;
   localparam int NB_GCLOSE        = 1;
   localparam int NB_LIMIT         = 2;
   localparam int NB_FINISH        = 3;
   localparam int EDGE_BIT_OFS     = 16;  // counting edges live in bytes 10 and 11

   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_PROC = 2'h1;
   localparam logic [1:0] SEL_DIAG = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   localparam logic [CTRL_W-1:0]   CTRL_RST   = 12'h000;
   localparam logic [EVT_EN_W-1:0] EVT_EN_RST = 20'h00000;

   typedef enum logic [1:0] {
      CCER_MODE_COUNT = 2'b00,
      CCER_MODE_FREQ  = 2'b01,
      CCER_MODE_PWM   = 2'b10,
      CCER_MODE_OFF   = 2'b11
   } ccer_mode_t;

   // one channel's event strobes, single-cycle pulses
   typedef struct packed {
      logic count_edge;   // counting edge seen
      logic finish;       // comparator response or end of measurement
      logic limit;        // overflow/underflow or frequency limit violation
      logic gate_close;   // hardware gate closing
      logic gate_open;    // hardware gate opening
   } ccer_chan_evt_t;

endpackage

// ===== hw/ccer_top.sv
// event and error reporting for four counter channels, wishbone slave
// assumes events are one-cycle pulses synchronous to clk_sys
// Overview of operation
// - diagnostic interrupt on incoming and outgoing errors when enabled
// - raising diagnostic interrupt never touches channel operation
// - outgoing reported only after every pending error has cleared
// - faulty flag set while errors queued, clears after outgoing report
// - diagnostic byte a bit 7 config error, byte b bit 6 lost interrupt
// - repeated event before acknowledge flags a lost process interrupt
// - process interrupt needs global selection and per-event enable
// - every report carries the submodule source address
// - process cause is a 32-bit word laid out by channel mode
// - counting mode uses gate open, gate close, overflow, comparator bits
// - counting edge sets bit 0 or 4 of bytes 10 and 11
// - frequency mode uses gate open, close, limit, end of measurement
// - frequency and pwm modes leave bytes 10 and 11 empty
// - pwm mode reports only gate opening, bit 0 or 4
// - interrupt with no handler installed enters the halted state
// - diagnostic error lights fault indicator and logs incoming in history
// - pwm event is hardware gate opening while software gate closed
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ccer_top
   import ccer_pkg::*;
#(
   parameter int              ADDR_W       = 12,
   parameter logic [15:0]     SUBMOD_ADDR  = 16'h0300  // value is arbitrary
) (
   input  wire logic                       clk_sys,                // system clock
   input  wire logic                       sys_rst,                // async reset
   input  wire logic                       wb_cyc_i,               // bus cycle
   input  wire logic                       wb_stb_i,               // strobe
   input  wire logic                       wb_we_i,                // write
   input  wire logic [ADDR_W-1:0]          wb_adr_i,               // byte address
   input  wire logic [3:0]                 wb_sel_i,               // byte lanes
   input  wire logic [31:0]                wb_dat_i,               // write data
   output logic [31:0]                     wb_dat_o,               // read data
   output logic                            wb_ack_o,               // acknowledge
   input  wire ccer_chan_evt_t [CCER_NCHAN-1:0] chan_evt_i,        // channel events
   input  wire logic [CCER_NCHAN-1:0]      hardware_gate,          // gate levels
   input  wire logic [CCER_NCHAN-1:0]      software_gate,          // gate levels
   input  wire logic                       cfg_err_i,              // config error level
   output logic                            process_irq_o,          // process interrupt
   output logic                            diag_irq_o,             // diagnostic interrupt
   output logic                            system_fault_indicator, // fault lamp
   output logic                            halted_o,               // halted state
   output logic                            irq                     // summary interrupt
);

   logic                  ack_q;
   logic [31:0]           rdat_q;
   logic [CTRL_W-1:0]     ctrl_q;
   logic [EVT_EN_W-1:0]   evt_en_q;
   logic [ST_W-1:0]       st_q, st_en_q;
   logic [31:0]           cause_q, cause_d;
   logic                  proc_irq_q, diag_irq_q, halt_q;
   logic                  lost_q, faulty_q;
   logic [1:0]            err_prev_q;
   logic [7:0]            dcause_a_q, dcause_b_q;
   logic [CCER_NCHAN-1:0] gate_prev_q;
   logic [7:0]            hist_cnt_q;
   logic                  hist_last_q;

   logic [7:0]            idx;
   logic                  req, wr;
   logic [31:0]           wmask;
   logic [31:0]           ev_word;
   logic                  proc_sel, diag_sel, proc_ack, diag_ack, halt_rel;
   logic                  proc_fire, lost_evt, incoming, outgoing, diag_fire;
   logic [1:0]            err_vec;
   logic [ST_W-1:0]       st_set, st_clr;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // four cause bits of one channel for its active mode
   function automatic logic [3:0] cause_nib(input ccer_mode_t m, input ccer_chan_evt_t e,
                                            input logic [EVT_EN_PER_CH-1:0] en,
                                            input logic pwm_open);
      logic [3:0] n;
      n = 4'h0;
      case (m)
         CCER_MODE_COUNT,
         CCER_MODE_FREQ: begin
            n[NB_GOPEN]  = e.gate_open;
            n[NB_GCLOSE] = e.gate_close;
            n[NB_LIMIT]  = e.limit;
            n[NB_FINISH] = e.finish;
         end
         CCER_MODE_PWM: begin
            n[NB_GOPEN]  = pwm_open;
         end
         default: n = 4'h0;
      endcase
      cause_nib = n & en[3:0];
   endfunction

   assign idx   = wb_adr_i[9:2];
   assign req   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr    = req & wb_we_i;
   assign wmask = lane_mask(wb_sel_i);

   assign proc_sel = (ctrl_q[CTRL_SEL_LSB+:2] == SEL_PROC) | (ctrl_q[CTRL_SEL_LSB+:2] == SEL_BOTH);
   assign diag_sel = (ctrl_q[CTRL_SEL_LSB+:2] == SEL_DIAG) | (ctrl_q[CTRL_SEL_LSB+:2] == SEL_BOTH);

   assign proc_ack = wr & (idx == IDX_ACK) & wb_sel_i[0] & wb_dat_i[ACK_PROC_BIT];
   assign diag_ack = wr & (idx == IDX_ACK) & wb_sel_i[0] & wb_dat_i[ACK_DIAG_BIT];
   assign halt_rel = wr & (idx == IDX_ACK) & wb_sel_i[0] & wb_dat_i[ACK_HALT_BIT];

   // build the cause word from all channels
   always_comb begin
      ev_word = 32'h0;
      for (int c = 0; c < CCER_NCHAN; c++) begin
         ccer_mode_t m;
         logic       pwm_open;
         logic [4:0] en;
         m        = ccer_mode_t'(ctrl_q[CTRL_MODE_LSB + 2*c +: 2]);
         en       = evt_en_q[EVT_EN_PER_CH*c +: EVT_EN_PER_CH];
         pwm_open = hardware_gate[c] & ~gate_prev_q[c] & ~software_gate[c];
         ev_word[4*c +: 4] = cause_nib(m, chan_evt_i[c], en, pwm_open);
         if (m == CCER_MODE_COUNT) begin
            ev_word[EDGE_BIT_OFS + 4*c] = chan_evt_i[c].count_edge & en[4];
         end
      end
      if (!proc_sel) begin
         ev_word = 32'h0;
      end
   end

   assign proc_fire = |ev_word;
   assign lost_evt  = |(ev_word & cause_q);
   assign cause_d   = (proc_ack ? 32'h0 : cause_q) | ev_word;

   assign err_vec   = {lost_q, cfg_err_i};
   assign incoming  = |(err_vec & ~err_prev_q);
   assign outgoing  = (|err_prev_q) & ~(|err_vec);
   assign diag_fire = diag_sel & (incoming | outgoing);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q <= req;
         if (req && !wb_we_i) begin
            if (idx == IDX_CTRL) begin
               rdat_q <= {20'h0, ctrl_q};
            end else if (idx == IDX_EVT_EN) begin
               rdat_q <= {12'h0, evt_en_q};
            end else if (idx == IDX_IRQ_STAT) begin
               rdat_q <= {27'h0, st_q};
            end else if (idx == IDX_IRQ_EN) begin
               rdat_q <= {27'h0, st_en_q};
            end else if (idx == IDX_PROC_SRC || idx == IDX_DIAG_SRC) begin
               rdat_q <= {16'h0, SUBMOD_ADDR};
            end else if (idx == IDX_HISTORY) begin
               rdat_q <= {23'h0, hist_last_q, hist_cnt_q};
            end else if (idx == IDX_PCAUSE_A) begin
               rdat_q <= {24'h0, cause_q[7:0]};
            end else if (idx == IDX_PCAUSE_B) begin
               rdat_q <= {24'h0, cause_q[15:8]};
            end else if (idx == IDX_PCAUSE_C) begin
               rdat_q <= {24'h0, cause_q[23:16]};
            end else if (idx == IDX_PCAUSE_D) begin
               rdat_q <= {24'h0, cause_q[31:24]};
            end else if (idx == IDX_DCAUSE_A) begin
               rdat_q <= {24'h0, dcause_a_q};
            end else if (idx == IDX_DCAUSE_B) begin
               rdat_q <= {24'h0, dcause_b_q};
            end else begin
               rdat_q <= 32'h0;
            end
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // configuration registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q   <= CTRL_RST;
         evt_en_q <= EVT_EN_RST;
         st_en_q  <= '0;
      end else if (wr) begin
         if (idx == IDX_CTRL) begin
            ctrl_q <= (ctrl_q & ~wmask[CTRL_W-1:0]) | (wb_dat_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
         end else if (idx == IDX_EVT_EN) begin
            evt_en_q <= (evt_en_q & ~wmask[EVT_EN_W-1:0])
                      | (wb_dat_i[EVT_EN_W-1:0] & wmask[EVT_EN_W-1:0]);
         end else if (idx == IDX_IRQ_EN && wb_sel_i[0]) begin
            st_en_q <= wb_dat_i[ST_W-1:0];
         end
      end
   end

   // process cause word and process interrupt line
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cause_q        <= 32'h0;
         proc_irq_q     <= 1'b0;
         gate_prev_q    <= '0;
      end else begin
         cause_q        <= cause_d;
         gate_prev_q    <= hardware_gate;
         if (proc_fire) begin
            proc_irq_q <= 1'b1; // set wins over acknowledge
         end else if (proc_ack) begin
            proc_irq_q <= 1'b0;
         end
      end
   end

   // error tracking; lost error stays pending until the diagnostic acknowledge
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lost_q     <= 1'b0;
         err_prev_q <= 2'b00;
         faulty_q   <= 1'b0;
         dcause_a_q <= 8'h00;
         dcause_b_q <= 8'h00;
         diag_irq_q <= 1'b0;
      end else begin
         if (lost_evt) begin
            lost_q <= 1'b1;
         end else if (diag_ack) begin
            lost_q <= 1'b0;
         end
         err_prev_q <= err_vec;
         if (|err_vec) begin
            faulty_q <= 1'b1;
         end else if (outgoing) begin
            faulty_q <= 1'b0;
         end
         if (incoming | outgoing) begin
            dcause_a_q <= 8'h00;
            dcause_b_q <= 8'h00;
            dcause_a_q[DA_FAULTY_BIT] <= |err_vec;
            dcause_a_q[DA_CFG_BIT]    <= err_vec[0];
            dcause_b_q[DB_LOST_BIT]   <= err_vec[1];
         end
         if (diag_fire) begin
            diag_irq_q <= 1'b1;
         end else if (diag_ack) begin
            diag_irq_q <= 1'b0;
         end
      end
   end

   // halted state and diagnostic history
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         halt_q      <= 1'b0;
         hist_cnt_q  <= 8'h00;
         hist_last_q <= 1'b0;
      end else begin
         if ((proc_fire && !ctrl_q[CTRL_PHND_BIT]) || (diag_fire && !ctrl_q[CTRL_DHND_BIT])) begin
            halt_q <= 1'b1;
         end else if (halt_rel) begin
            halt_q <= 1'b0;
         end
         if (incoming) begin
            hist_cnt_q  <= hist_cnt_q + 8'h01;
            hist_last_q <= 1'b1;
         end else if (outgoing) begin
            hist_last_q <= 1'b0;
         end
      end
   end

   // sticky status with write-one-to-clear; set wins
   assign st_set = {halt_q & ~halt_rel, lost_evt, diag_fire & outgoing,
                    diag_fire & incoming, proc_fire};
   assign st_clr = (wr && idx == IDX_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[ST_W-1:0] : '0;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= (st_q & ~st_clr) | st_set;
      end
   end

   // no output here reaches channel logic, so counting is never paused
   assign process_irq_o          = proc_irq_q;
   assign diag_irq_o             = diag_irq_q;
   assign system_fault_indicator = faulty_q;
   assign halted_o               = halt_q;
   assign irq                    = |(st_q & st_en_q);

endmodule
`default_nettype wire

// ===== test/ccer_chan_model.sv
// channel-side model: event strobes and gate levels for the four channels
// assumes the bench calls its tasks; everything changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ccer_chan_model
   import ccer_pkg::*;
(
   input  wire logic                        clk_sys,  // system clock
   output var ccer_chan_evt_t [CCER_NCHAN-1:0] chan_evt, // event strobes
   output var logic [CCER_NCHAN-1:0]        hardware_gate, // hardware gate levels
   output var logic [CCER_NCHAN-1:0]        software_gate  // software gate levels
);
   initial begin
      chan_evt      = '0;
      hardware_gate = '0;
      software_gate = '0;
   end
   // strobes last exactly one cycle, as real channel logic gives them
   task automatic pulse(input int c, input ccer_chan_evt_t e);
      @(posedge clk_sys);
      chan_evt[c] <= e;
      @(posedge clk_sys);
      chan_evt[c] <= '0;
   endtask
   // hardware gate opens with the software gate held at sw
   task automatic gate_open(input int c, input logic sw);
      @(posedge clk_sys);
      software_gate[c] <= sw;
      @(posedge clk_sys);
      hardware_gate[c] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      hardware_gate[c] <= 1'b0;
      software_gate[c] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test/ccer_top_asserts.sv
// port-level checker for the event reporting block
// assumes one clock domain, reset asynchronous and active high
`timescale 1ns/1ps
`default_nettype none
module ccer_top_asserts
   import ccer_pkg::*;
#(
   parameter int          ADDR_W      = 12,
   parameter logic [15:0] SUBMOD_ADDR = 16'h0300
) (
   input wire logic                        clk_sys,                // clock
   input wire logic                        sys_rst,                // reset
   input wire logic                        wb_cyc_i,               // cycle
   input wire logic                        wb_stb_i,               // strobe
   input wire logic                        wb_we_i,                // write
   input wire logic [ADDR_W-1:0]           wb_adr_i,               // address
   input wire logic [3:0]                  wb_sel_i,               // lanes
   input wire logic [31:0]                 wb_dat_i,               // write data
   input wire logic [31:0]                 wb_dat_o,               // read data
   input wire logic                        wb_ack_o,               // ack
   input wire ccer_chan_evt_t [CCER_NCHAN-1:0] chan_evt_i,         // events
   input wire logic [CCER_NCHAN-1:0]       hardware_gate,          // gates
   input wire logic [CCER_NCHAN-1:0]       software_gate,          // gates
   input wire logic                        cfg_err_i,              // config error
   input wire logic                        process_irq_o,          // process irq
   input wire logic                        diag_irq_o,             // diag irq
   input wire logic                        system_fault_indicator, // fault lamp
   input wire logic                        halted_o,               // halted
   input wire logic                        irq                     // summary irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic       take;
   logic [7:0] idx;
   logic       ack_wr;
   assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign idx    = wb_adr_i[9:2];
   assign ack_wr = take & wb_we_i & (idx == IDX_ACK) & wb_sel_i[0];
   property p_ack_resp; take |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_src;
      take && !wb_we_i && (idx == IDX_PROC_SRC || idx == IDX_DIAG_SRC)
         |=> wb_dat_o == {16'h0000, SUBMOD_ADDR};
   endproperty
   a_src: assert property (p_src) else $error("source address wrong");
   property p_wo_zero;
      take && !wb_we_i && (idx == IDX_ACK || idx == IDX_IRQ_CLR) |=> wb_dat_o == 32'h0;
   endproperty
   a_wo_zero: assert property (p_wo_zero) else $error("write-only register read nonzero");
   property p_proc_cause;
      $rose(process_irq_o) |-> $past(|chan_evt_i) || $past(|(hardware_gate & ~software_gate));
   endproperty
   a_proc_cause: assert property (p_proc_cause) else $error("stray process irq");
   property p_proc_hold;
      process_irq_o && !(ack_wr && wb_dat_i[ACK_PROC_BIT]) |=> process_irq_o;
   endproperty
   a_proc_hold: assert property (p_proc_hold) else $error("process irq dropped early");
   property p_proc_clr;
      ack_wr && wb_dat_i[ACK_PROC_BIT] && chan_evt_i == '0 && $stable(hardware_gate)
         |=> !process_irq_o;
   endproperty
   a_proc_clr: assert property (p_proc_clr) else $error("process irq not cleared");
   property p_diag_hold; diag_irq_o && !(ack_wr && wb_dat_i[ACK_DIAG_BIT]) |=> diag_irq_o;
   endproperty
   a_diag_hold: assert property (p_diag_hold) else $error("diag irq dropped early");
   property p_halt_why; $rose(halted_o) |-> process_irq_o || diag_irq_o; endproperty
   a_halt_why: assert property (p_halt_why) else $error("halt without interrupt");
   property p_halt_hold; halted_o && !(ack_wr && wb_dat_i[ACK_HALT_BIT]) |=> halted_o;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
   property p_fault; cfg_err_i |-> ##[1:2] system_fault_indicator; endproperty
   a_fault: assert property (p_fault) else $error("fault lamp off with error");
endmodule
bind ccer_top ccer_top_asserts #(.ADDR_W(ADDR_W), .SUBMOD_ADDR(SUBMOD_ADDR)) ccer_top_asserts_i (.*);
`default_nettype wire

// ===== test/counter_channel_event_reporting_bench.sv
// self-checking bench for the event reporting block
// assumes the channel model drives events; bench is the bus master
`timescale 1ns/1ps
`default_nettype none
module counter_channel_event_reporting_bench
   import ccer_pkg::*;
;
   localparam logic [15:0] SUBMOD = 16'h0a5c; // value is arbitrary
   logic clk_sys, sys_rst, cyc, stb, we, cfg_err, wb_ack_o, irq;
   logic process_irq_o, diag_irq_o, system_fault_indicator, halted_o;
   logic [11:0] adr;
   logic [3:0]  sel;
   logic [31:0] wdat, wb_dat_o;
   ccer_chan_evt_t [CCER_NCHAN-1:0] evt;
   logic [CCER_NCHAN-1:0] hwg, swg;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   ccer_chan_model ccer_chan_model_i (.clk_sys(clk_sys), .chan_evt(evt), .hardware_gate(hwg),
      .software_gate(swg));
   ccer_top #(.ADDR_W(12), .SUBMOD_ADDR(SUBMOD)) ccer_top_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .chan_evt_i(evt), .hardware_gate(hwg), .software_gate(swg), .cfg_err_i(cfg_err),
      .process_irq_o(process_irq_o), .diag_irq_o(diag_irq_o),
      .system_fault_indicator(system_fault_indicator), .halted_o(halted_o), .irq(irq));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic wrap_up;
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // generous ceiling, the whole run needs under a thousand cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // holds the request until ack is sampled high, then releases it
   task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, idx, 2'b00};
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, idx, d, q);
      idle(1);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, idx, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic cause_chk(input logic [31:0] exp);
      for (int k = 0; k < 4; k++) rd_chk(IDX_PCAUSE_A + 8'(k), 32'(exp[8*k +: 8]));
   endtask
   function automatic logic [31:0] ctrl(logic [1:0] s, logic [1:0] m, logic h);
      return {20'h0, h, h, m, m, m, m, s};
   endfunction
   task automatic t_reset;
      rd_chk(IDX_CTRL, 32'(CTRL_RST));
      rd_chk(IDX_EVT_EN, 32'(EVT_EN_RST));
      rd_chk(IDX_PROC_SRC, {16'h0, SUBMOD});
      rd_chk(IDX_DIAG_SRC, {16'h0, SUBMOD});
      rd_chk(8'h3f, 32'h0);
      rd_chk(IDX_ACK, 32'h0);
      rd_chk(IDX_IRQ_CLR, 32'h0);
      cause_chk(32'h0);
   endtask
   task automatic t_halt;
      wr(IDX_CTRL, ctrl(SEL_PROC, CCER_MODE_COUNT, 1'b0));
      wr(IDX_EVT_EN, 32'h000fffff);
      ccer_chan_model_i.pulse(0, 5'h01);
      idle(2);
      chk(halted_o, 1'b1);
      rd_chk(IDX_IRQ_STAT, 32'h11);
      wr(IDX_ACK, 32'h7);
      wr(IDX_IRQ_CLR, 32'h1f);
      chk(halted_o, 1'b0);
      rd_chk(IDX_IRQ_STAT, 32'h0);
   endtask
   // counting, frequency and pwm modes on every channel: all strobes plus gate openings
   task automatic t_modes;
      logic [31:0] e;
      for (int m = 0; m < 3; m++) begin
         wr(IDX_CTRL, ctrl(SEL_PROC, 2'(m), 1'b1));
         for (int c = 0; c < CCER_NCHAN; c++) begin
            ccer_chan_model_i.pulse(c, 5'h1f);
            ccer_chan_model_i.gate_open(c, 1'b0);
            idle(2);
            e = (m == 0) ? (32'hf << 4*c) | (32'h1 << (16 + 4*c)) :
                (m == 1) ? 32'hf << 4*c : 32'h1 << 4*c;
            chk(process_irq_o, 1'b1);
            cause_chk(e);
            wr(IDX_ACK, 32'h1);
            ccer_chan_model_i.gate_open(c, 1'b1);
            idle(2);
            chk(process_irq_o, 1'b0);
            cause_chk(32'h0);
         end
      end
      wr(IDX_IRQ_CLR, 32'h1f);
   endtask
   task automatic t_refuse;
      wr(IDX_CTRL, ctrl(SEL_DIAG, CCER_MODE_COUNT, 1'b1));
      ccer_chan_model_i.pulse(1, 5'h1f);
      idle(2);
      chk(process_irq_o, 1'b0);
      wr(IDX_CTRL, ctrl(SEL_PROC, CCER_MODE_OFF, 1'b1));
      ccer_chan_model_i.pulse(0, 5'h1f);
      ccer_chan_model_i.gate_open(0, 1'b0);
      idle(2);
      chk(process_irq_o, 1'b0);
      wr(IDX_CTRL, ctrl(SEL_PROC, CCER_MODE_COUNT, 1'b1));
      wr(IDX_EVT_EN, 32'h0);
      ccer_chan_model_i.pulse(2, 5'h1f);
      idle(2);
      chk(process_irq_o, 1'b0);
      cause_chk(32'h0);
      wr(IDX_EVT_EN, 32'h000fffff);
   endtask
   task automatic t_irq;
      wr(IDX_IRQ_EN, 32'h1);
      rd_chk(IDX_IRQ_EN, 32'h1);
      ccer_chan_model_i.pulse(3, 5'h01);
      idle(2);
      chk(irq, 1'b1);
      wr(IDX_IRQ_EN, 32'h0);
      chk(irq, 1'b0);
      wr(IDX_IRQ_EN, 32'h1);
      wr(IDX_ACK, 32'h1);
      wr(IDX_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
      wr(IDX_IRQ_EN, 32'h0);
   endtask
   // lost interrupt and config error overlap; outgoing only when both are gone
   task automatic t_diag;
      wr(IDX_CTRL, ctrl(SEL_BOTH, CCER_MODE_COUNT, 1'b1));
      ccer_chan_model_i.pulse(0, 5'h01);
      ccer_chan_model_i.pulse(0, 5'h01);
      idle(3);
      chk(diag_irq_o, 1'b1);
      chk(system_fault_indicator, 1'b1);
      rd_chk(IDX_DCAUSE_B, 32'h40);
      rd_chk(IDX_HISTORY, 32'h101);
      @(posedge clk_sys) cfg_err <= 1'b1;
      idle(3);
      rd_chk(IDX_DCAUSE_A, 32'h81);
      wr(IDX_ACK, 32'h3);
      wr(IDX_IRQ_CLR, 32'h1f);
      idle(2);
      rd_chk(IDX_IRQ_STAT, 32'h0);
      chk(system_fault_indicator, 1'b1);
      @(posedge clk_sys) cfg_err <= 1'b0;
      idle(3);
      rd_chk(IDX_IRQ_STAT, 32'h4);
      chk(diag_irq_o, 1'b1);
      chk(system_fault_indicator, 1'b0);
      rd_chk(IDX_DCAUSE_A, 32'h0);
      rd_chk(IDX_HISTORY, 32'h002);
   endtask
   initial begin
      {cyc, stb, we, cfg_err, adr, sel, wdat} = '0;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_halt();
      t_modes();
      t_refuse();
      t_irq();
      t_diag();
      wrap_up();
   end
endmodule
`default_nettype wire
